// ---- shared/dfi_defs.vh ----
// Purpose: constants for the decrement file instruction slice
// Assumes: one quarter-cycle per clk edge at 200 MHz
// Notes:   bus offsets and opcode fields are defined here; the checker and bench repeat them as literals
`ifndef DFI_DEFS_VH
`define DFI_DEFS_VH

// ****************************************
// instruction word layout
// ****************************************
`define DFI_IW_W        14
`define DFI_OPC_HI      13
`define DFI_OPC_LO      8
`define DFI_DEST_BIT    7
`define DFI_FADDR_HI    6
`define DFI_OPC_DEC     6'h03
`define DFI_OPC_DSZ     6'h0b
`define DFI_NOP_WORD    14'h0000

// ****************************************
// quarter-cycle timing
// ****************************************
`define DFI_CLK_NS      5
`define DFI_QTR_NS      5
`define DFI_QTR_CYC     (`DFI_QTR_NS / `DFI_CLK_NS)
`define DFI_Q1          2'h0
`define DFI_Q2          2'h1
`define DFI_Q3          2'h2
`define DFI_Q4          2'h3

// ****************************************
// register bus map
// ****************************************
`define DFI_AW          8
`define DFI_FILE_N      128
`define DFI_A_WREG      8'h80
`define DFI_A_STAT      8'h81
`define DFI_A_CTRL      8'h82
`define DFI_A_STATE     8'h83
`define DFI_A_PCL       8'h84
`define DFI_A_PCH       8'h85

// status bits
`define DFI_ST_C        0
`define DFI_ST_DC       1
`define DFI_ST_Z        2
`define DFI_PC_W        13
`define DFI_PC_RST      13'h0000
`define DFI_BYTE_RST    8'h00
`define DFI_BYTE_ONE    8'h01

`endif

// ---- hdl/dfi_decode.v ----
// Purpose: split an instruction word into decrement controls
// Assumes: flush marks a fetched word that must run as a no-op
// Notes:   every other opcode decodes to no action here
`timescale 1ns/1ps
`include "dfi_defs.vh"

module dfi_decode (
  input  wire [13:0] ir,
  input  wire        flush,
  output wire        is_dec,
  output wire        is_skip,
  output wire        dest_file,
  output wire [6:0]  file_addr
);

  // ****************************************
  // opcode match
  // ****************************************
  wire [5:0] opc;
  wire       live;

  assign opc       = ir[`DFI_OPC_HI:`DFI_OPC_LO];
  // a flushed word is a bubble, whatever its bits say
  assign live      = ~flush;
  assign is_dec    = live & (opc == `DFI_OPC_DEC);
  assign is_skip   = live & (opc == `DFI_OPC_DSZ);
  assign dest_file = ir[`DFI_DEST_BIT];
  assign file_addr = ir[`DFI_FADDR_HI:0];

endmodule // dfi_decode

// ---- hdl/dfi_regfile.v ----
// Purpose: 128 byte file register store in flip-flops
// Assumes: one write port, two combinational read ports
// Notes:   caller arbitrates the single write port
`timescale 1ns/1ps
`include "dfi_defs.vh"

module dfi_regfile (
  input  wire       clk,
  input  wire       nrst,
  input  wire       we,
  input  wire [6:0] waddr,
  input  wire [7:0] wdata,
  input  wire [6:0] raddr_a,
  output wire [7:0] rdata_a,
  input  wire [6:0] raddr_b,
  output wire [7:0] rdata_b
);

  // ****************************************
  // storage
  // ****************************************
  reg [7:0] mem [0:`DFI_FILE_N-1];

  // one write-enabled byte per entry
  genvar i;
  generate
    for (i = 0; i < `DFI_FILE_N; i = i + 1) begin : g_ent
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          mem[i] <= `DFI_BYTE_RST;
        end else if (we && ({25'h000_0000, waddr} == i)) begin
          mem[i] <= wdata;
        end
      end
    end
  endgenerate

  // read ports by index
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule // dfi_regfile

// ---- hdl/dfi_core.v ----
// Purpose: execute slice for the decrement file instructions
// Assumes: program word arrives in step with fetch_strobe
// Notes:   four clk edges make one instruction cycle
//
// How it works
// - opcode 000011 decodes; d bit, 7-bit address
// - d=0 puts file value minus one in W
// - d=1 writes decremented value back to file
// - only zero flag changes; carry bits kept
// - one word, one cycle over four quarters
// - skip variant skips next word on zero
// - skipped word runs as no-op, two cycles
`timescale 1ns/1ps
`include "dfi_defs.vh"

module dfi_core (
  input  wire        clk,
  input  wire        nrst,
  // program memory side
  output wire [12:0] prog_addr,
  input  wire [13:0] instr_word,
  output wire        fetch_strobe,
  // register bus
  input  wire [7:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  // live state
  output wire [7:0]  w_out,
  output wire        zero_flag,
  output wire        skip_active
);

  // ****************************************
  // instruction cycle at a glance
  // ****************************************
  // one instruction cycle is four clk periods, one per quarter
  // in Q1 the word in ir is decoded; a flushed word decodes to nothing
  // in Q2 the addressed file byte is copied into operand
  // in Q3 operand minus one is held in result
  // in Q4 result lands in W or the file, and Z follows it;
  //   the next word is latched and pc steps by one
  //
  // why separate operand and result registers:
  //   the file read port is combinational, so holding the
  //   byte in Q2 keeps the subtract away from a bus write
  //   that may land on the same entry in Q3
  //
  // skip handling:
  //   the following word is already in flight at the Q4
  //   edge that learns the result, so it is not refetched;
  //   flush marks it instead and it runs as a bubble for
  //   one whole cycle, which gives the two-cycle cost
  //
  // bus arbitration:
  //   in a live decrement's Q4 the core owns the file write port or W;
  //   software writes that meet it there are dropped,
  //   so software should halt the core before poking
  //   registers that the program is using
  //
  // reset:
  //   everything clears, ir holds a no-op word and the
  //   core stays halted until software sets run
  //
  // limitations:
  //   no other opcode does anything; fetch is a plain
  //   counter with no branch, stack or interrupt;
  //   clearing run parks the phase at Q1 and abandons
  //   any half-done cycle
  //

  // ****************************************
  // state
  // ****************************************
  reg  [1:0]  qph;        // quarter-cycle phase
  reg  [13:0] ir;         // word under execution
  reg         flush;      // ir is a skipped word
  reg  [12:0] pc;
  reg  [7:0]  wreg;
  reg  [7:0]  operand;    // latched in Q2
  reg  [7:0]  result;     // formed in Q3
  reg         flag_c;
  reg         flag_dc;
  reg         flag_z;
  reg         run;
  reg         last_dec;   // last executed word was a live decrement; a bubble clears it

  reg  [1:0]  next_qph;
  reg         next_flush;

  wire        is_dec;
  wire        is_skip;
  wire        dest_file;
  wire [6:0]  file_addr;
  wire        any_dec;
  wire [7:0]  file_rd;
  wire [7:0]  bus_file_rd;
  wire        q4;
  wire        core_wf;
  wire        core_ww;
  wire        bus_wf;
  wire        rf_we;
  wire [6:0]  rf_waddr;
  wire [7:0]  rf_wdata;
  wire [7:0]  dec_val;
  wire        dec_zero;

  // ****************************************
  // decode and file store
  // ****************************************
  dfi_decode u_dec (
    .ir        (ir),
    .flush     (flush),
    .is_dec    (is_dec),
    .is_skip   (is_skip),
    .dest_file (dest_file),
    .file_addr (file_addr)
  );

  dfi_regfile u_rf (
    .clk     (clk),
    .nrst    (nrst),
    .we      (rf_we),
    .waddr   (rf_waddr),
    .wdata   (rf_wdata),
    .raddr_a (file_addr),
    .rdata_a (file_rd),
    .raddr_b (addr[6:0]),
    .rdata_b (bus_file_rd)
  );

  // ****************************************
  // quarter-cycle sequencer
  // ****************************************
  assign q4      = run && (qph == `DFI_Q4);
  assign any_dec = is_dec | is_skip;

  // phase walks Q1..Q4 while running, parks at Q1 when halted
  always @* begin
    next_qph = qph;
    if (!run) begin
      next_qph = `DFI_Q1;
    end else begin
      case (qph)
        `DFI_Q1: next_qph = `DFI_Q2;
        `DFI_Q2: next_qph = `DFI_Q3;
        `DFI_Q3: next_qph = `DFI_Q4;
        `DFI_Q4: next_qph = `DFI_Q1;
        default: next_qph = `DFI_Q1;
      endcase
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      qph <= `DFI_Q1;
    end else begin
      qph <= next_qph;
    end
  end

  // ****************************************
  // datapath: read Q2, subtract Q3
  // ****************************************
  // wraps modulo 256 so zero becomes FF
  assign dec_val  = operand - `DFI_BYTE_ONE;
  assign dec_zero = (result == `DFI_BYTE_RST);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      operand <= `DFI_BYTE_RST;
      result  <= `DFI_BYTE_RST;
    end else begin
      if (run && (qph == `DFI_Q2)) begin
        operand <= file_rd;
      end
      if (run && (qph == `DFI_Q3)) begin
        result <= dec_val;
      end
    end
  end

  // ****************************************
  // destination write in Q4
  // ****************************************
  assign core_wf = q4 && any_dec && dest_file;
  assign core_ww = q4 && any_dec && !dest_file;
  // core owns the port in its Q4; a colliding bus write is lost
  assign bus_wf  = wr && !addr[7] && !core_wf;

  assign rf_we    = core_wf | bus_wf;
  assign rf_waddr = core_wf ? file_addr : addr[6:0];
  assign rf_wdata = core_wf ? result : wdata;

  // working register: core result first, else bus
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wreg <= `DFI_BYTE_RST;
    end else if (core_ww) begin
      wreg <= result;
    end else if (wr && (addr == `DFI_A_WREG)) begin
      wreg <= wdata;
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  // carry bits only ever move by software
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_c  <= 1'b0;
      flag_dc <= 1'b0;
      flag_z  <= 1'b0;
    end else begin
      if (wr && (addr == `DFI_A_STAT)) begin
        flag_c  <= wdata[`DFI_ST_C];
        flag_dc <= wdata[`DFI_ST_DC];
      end
      // hardware update beats a same-cycle software write
      if (q4 && any_dec) begin
        flag_z <= dec_zero;
      end else if (wr && (addr == `DFI_A_STAT)) begin
        flag_z <= wdata[`DFI_ST_Z];
      end
    end
  end

  // ****************************************
  // fetch pipeline and skip
  // ****************************************
  // the next word is already fetched when the result is known,
  // so a skip turns it into a bubble instead of moving pc twice
  always @* begin
    next_flush = flush;
    if (q4) begin
      next_flush = is_skip && dec_zero;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ir    <= `DFI_NOP_WORD;
      flush <= 1'b0;
      pc    <= `DFI_PC_RST;
    end else begin
      flush <= next_flush;
      if (q4) begin
        ir <= instr_word;
        pc <= pc + 13'h0001;
      end else if (wr && (addr == `DFI_A_PCL)) begin
        pc <= {pc[12:8], wdata};
      end else if (wr && (addr == `DFI_A_PCH)) begin
        pc <= {wdata[4:0], pc[7:0]};
      end
    end
  end

  assign prog_addr    = pc;
  assign fetch_strobe = q4;

  // ****************************************
  // control and observation
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run      <= 1'b0;
      last_dec <= 1'b0;
    end else begin
      if (wr && (addr == `DFI_A_CTRL)) begin
        run <= wdata[0];
      end
      if (q4) begin
        last_dec <= any_dec;
      end
    end
  end

  // ****************************************
  // register bus read, one cycle late
  // ****************************************
  // data stand only in the cycle after the strobe
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= `DFI_BYTE_RST;
    end else if (!rd) begin
      rdata <= `DFI_BYTE_RST;
    end else if (!addr[7]) begin
      rdata <= bus_file_rd;
    end else begin
      case (addr)
        `DFI_A_WREG:  rdata <= wreg;
        `DFI_A_STAT:  rdata <= {5'h00, flag_z, flag_dc, flag_c};
        `DFI_A_CTRL:  rdata <= {7'h00, run};
        `DFI_A_STATE: rdata <= {4'h0, last_dec, flush, qph};
        `DFI_A_PCL:   rdata <= pc[7:0];
        `DFI_A_PCH:   rdata <= {3'h0, pc[12:8]};
        default:      rdata <= `DFI_BYTE_RST;
      endcase
    end
  end

  assign w_out       = wreg;
  assign zero_flag   = flag_z;
  assign skip_active = flush;

endmodule // dfi_core

// ---- sim/dfi_core_asserts.sv ----
// Purpose: port-level checks for the decrement execute slice
// Assumes: run stays set once started
// Notes:   tracks the executing word from fetch_strobe
`timescale 1ns/1ps
module dfi_chk (
  input wire        clk,
  input wire        nrst,
  input wire [12:0] prog_addr,
  input wire [13:0] instr_word,
  input wire        fetch_strobe,
  input wire        wr,
  input wire [7:0]  w_out,
  input wire        zero_flag,
  input wire        skip_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ****
  // executing word, latched like the core does
  // ****
  reg  [13:0] ir_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) ir_q <= 14'h0000;
    else if (fetch_strobe) ir_q <= instr_word;
  end
  // a flushed word must not count as a decrement
  wire ex_dec = (ir_q[13:8] == 6'h03 || ir_q[13:8] == 6'h0b) && !skip_active;
  wire ex_w   = ex_dec && !ir_q[7];
  wire ex_sw  = ex_w && ir_q[13:8] == 6'h0b;
  property p_fs_period; fetch_strobe |=> !fetch_strobe [*3] ##1 fetch_strobe; endproperty
  a_fs_period: assert property (p_fs_period) else $error("fetch period wrong");
  property p_pc_step; fetch_strobe |=> prog_addr == $past(prog_addr) + 13'h0001; endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
  property p_pc_hold; !fetch_strobe && !wr |=> $stable(prog_addr); endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc moved");
  property p_z_res; fetch_strobe && ex_w |=> zero_flag == (w_out == 8'h00); endproperty
  a_z_res: assert property (p_z_res) else $error("zero flag wrong");
  property p_skip_res; fetch_strobe && ex_sw |=> skip_active == (w_out == 8'h00); endproperty
  a_skip_res: assert property (p_skip_res) else $error("skip decision wrong");
  property p_w_hold; fetch_strobe && !ex_w && !wr |=> $stable(w_out); endproperty
  a_w_hold: assert property (p_w_hold) else $error("w changed");
  property p_z_hold; (!fetch_strobe || !ex_dec) && !wr |=> $stable(zero_flag); endproperty
  a_z_hold: assert property (p_z_hold) else $error("zero flag moved");
  property p_skip_len; $rose(skip_active) |-> skip_active [*4] ##1 !skip_active; endproperty
  a_skip_len: assert property (p_skip_len) else $error("skip length wrong");
  c_skip: cover property ($rose(skip_active));
  c_zero: cover property (fetch_strobe && ex_w ##1 zero_flag);
  c_wdec: cover property (fetch_strobe && ex_w ##1 !zero_flag);
endmodule // dfi_chk
bind dfi_core dfi_chk u_chk (.clk(clk), .nrst(nrst), .prog_addr(prog_addr),
  .instr_word(instr_word), .fetch_strobe(fetch_strobe), .wr(wr), .w_out(w_out),
  .zero_flag(zero_flag), .skip_active(skip_active));

// ---- sim/tb_decrement_file_instr.sv ----
// Purpose: self-checking bench for the decrement execute slice
// Assumes: program served from a small table by prog_addr
// Notes:   reads queue their expectation, a monitor compares
`timescale 1ns/1ps
module tb_decrement_file_instr;
  logic        clk, nrst, wr, rd, rd_d;
  logic [7:0]  addr, wdata, r1, r2, r3, skip_n;
  logic [13:0] instr_word;
  logic [13:0] prog [0:7];
  logic [7:0]  exp_q [$];
  wire  [12:0] prog_addr;
  wire  [7:0]  rdata, w_out;
  wire         fetch_strobe, zero_flag, skip_active;
  int          bad_count, compares, n;
  dfi_core DUT (.clk(clk), .nrst(nrst), .prog_addr(prog_addr), .instr_word(instr_word),
    .fetch_strobe(fetch_strobe), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .w_out(w_out), .zero_flag(zero_flag), .skip_active(skip_active));
  // ****
  // clock, bus tasks, compare
  // ****
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic end_sim;
    $display("counts: compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1; exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // monitor: read data stands only in the cycle after rd
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) if (rd_d === 1'b1) chk8(rdata, exp_q.pop_front());
  // program memory; beyond the table only no-ops
  always @(posedge clk) begin
    instr_word <= (prog_addr < 13'h0008) ? prog[prog_addr[2:0]] : 14'h0000;
    if (!nrst) skip_n <= 8'h00;
    else if (skip_active === 1'b1) skip_n <= skip_n + 8'h01;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("MISMATCH t=%0t timeout", $time);
    end_sim();
  end
  // ****
  // main sequence
  // ****
  initial begin
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    n = 0;
    // W, file 127 boundary, wrap, no-skip, foreign op, skip, flushed word
    prog = '{14'h0305, 14'h03ff, 14'h0389, 14'h0b0a, 14'h0a05, 14'h0b87, 14'h0388, 14'h0000};
    r1 = 8'($urandom(15280));
    r2 = 8'($urandom);
    r3 = 8'($urandom);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    bus_rd(8'h80, 8'h00);
    bus_rd(8'h81, 8'h00);
    bus_wr(8'h83, 8'hff);
    bus_rd(8'h83, 8'h00);
    bus_rd(8'h90, 8'h00);
    $display("test reset_map done");
    bus_wr(8'h05, r1);
    bus_wr(8'h7f, r2);
    bus_wr(8'h09, 8'h00);
    bus_wr(8'h0a, 8'h02);
    bus_wr(8'h07, 8'h01);
    bus_wr(8'h08, r3);
    bus_wr(8'h81, 8'h03);
    bus_wr(8'h82, 8'h01);
    while (prog_addr !== 13'h000a && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n == 400) begin
      bad_count++;
      $display("MISMATCH t=%0t program stalled", $time);
      end_sim();
    end
    bus_rd(8'h80, 8'h01);
    bus_rd(8'h81, 8'h07);
    bus_rd(8'h05, r1);
    bus_rd(8'h7f, r2 - 8'h01);
    bus_rd(8'h07, 8'h00);
    bus_rd(8'h08, r3);
    bus_rd(8'h09, 8'hff);
    bus_rd(8'h0a, 8'h02);
    repeat (2) @(posedge clk);
    chk8(skip_n, 8'h04);
    $display("test run done");
    end_sim();
  end
endmodule // tb_decrement_file_instr
